// ---- design/fail_pin_pkg.sv ----
// package: register map, field layout and timing for the fail and alternate pin block
`default_nettype none
package fail_pin_pkg;
    localparam int          ADR_W           = 8;
    localparam int          DAT_W           = 32;
    localparam int          REG_W           = 8;
    // register byte offsets
    localparam logic [7:0]  OFS_CTRL        = 8'h00;
    localparam logic [7:0]  OFS_PIN_CTRL    = 8'h04;
    localparam logic [7:0]  OFS_STATUS      = 8'h08;
    localparam logic [7:0]  OFS_MASK        = 8'h0C;
    localparam logic [7:0]  OFS_INFO        = 8'h10;
    // control register fields
    localparam int          CTRL_SIDE_BIT   = 0;
    localparam int          CTRL_LIGHT_BIT  = 1;
    localparam int          CTRL_MEAS_BIT   = 2;
    localparam int          CTRL_W          = 3;
    localparam logic [2:0]  CTRL_RST        = 3'h0;
    // pin control: two bits of mode and one level bit per alternate pin
    localparam int          PIN_FIELD_W     = 4;
    localparam int          PIN_LVL_OFS     = 2;
    localparam logic [7:0]  PIN_CTRL_RST    = 8'h00;
    // status / mask bits
    localparam int          EV_FAIL_BIT     = 0;
    localparam int          EV_WAKE1_BIT    = 1;
    localparam int          EV_WAKE2_BIT    = 2;
    localparam int          EV_W            = 3;
    localparam logic [2:0]  EV_RST          = 3'h0;
    // info register fields
    localparam int          INFO_CFG13_BIT  = 0;
    localparam int          INFO_DEV_BIT    = 1;
    localparam int          INFO_RUN_BIT    = 2;
    // alternate pin functions
    typedef enum logic [1:0] {
        MODE_FAIL = 2'h0,
        MODE_WAKE = 2'h1,
        MODE_LOW  = 2'h2,
        MODE_HIGH = 2'h3
    } pin_mode_t;
    // timing
    localparam int          CLK_PERIOD_NS   = 5;
    localparam int          SIDE_PERIOD_NS  = 800_000_000;
    localparam int          SIDE_DUTY_PCT   = 50;
    localparam int          LIGHT_PERIOD_NS = 10_000_000;
    localparam int          LIGHT_DUTY_PCT  = 20;
    localparam int          STRAP_WAIT_NS   = 1_000;
    localparam int          PCT_FULL        = 100;
    localparam int          SIDE_PERIOD_CYC = SIDE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int          SIDE_ON_CYC     = SIDE_PERIOD_CYC / PCT_FULL * SIDE_DUTY_PCT;
    localparam int          LIGHT_PERIOD_CYC = LIGHT_PERIOD_NS / CLK_PERIOD_NS;
    localparam int          LIGHT_ON_CYC    = LIGHT_PERIOD_CYC / PCT_FULL * LIGHT_DUTY_PCT;
    localparam int          STRAP_WAIT_CYC  = (STRAP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          STRAP_CNT_W     = 12;
endpackage : fail_pin_pkg
`default_nettype wire

// ---- design/blink_if.sv ----
// interface: enable and pattern state between the pin logic and one blink generator
`default_nettype none
interface blink_if;
    logic en;
    logic active;
    modport gen  (input en, output active);
    modport user (output en, input active);
endinterface : blink_if
`default_nettype wire

// ---- design/blink_gen.sv ----
// blink pattern generator: fixed period and on-time from a free counter
`default_nettype none
module blink_gen #(
    parameter int PERIOD_CYC = 2_000_000,
    parameter int ON_CYC     = 400_000
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    blink_if.gen      bl
);
    localparam int CNT_W = $clog2(PERIOD_CYC);

    if (ON_CYC < 1 || ON_CYC >= PERIOD_CYC) begin : g_chk
        $error("blink_gen: on time must be at least one cycle and below the period");
    end

    typedef struct packed {
        logic             run;
        logic [CNT_W-1:0] cnt;
        logic             active;
    } blink_state_t;

    blink_state_t s_reg;
    blink_state_t s_next;

    always_comb begin
        s_next = s_reg;
        if (!bl.en) begin
            s_next.run = 1'b0;
            s_next.cnt = '0;
        end else if (!s_reg.run) begin
            // restart so the first period is full length
            s_next.run = 1'b1; // RULE11
            s_next.cnt = '0;
        end else if (s_reg.cnt == CNT_W'(PERIOD_CYC - 1)) begin
            s_next.cnt = '0;
        end else begin
            s_next.cnt = s_reg.cnt + CNT_W'(1);
        end
        s_next.active = bl.en && (s_next.cnt < CNT_W'(ON_CYC)); // RULE11
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bl.active = s_reg.active;

    a_blink_restart_clean: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
        !bl.en |=> !bl.active && s_reg.cnt == '0)
        else $error("blink pattern not cleared while disabled");
    a_blink_cnt_range: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
        {1'b0, s_reg.cnt} < (CNT_W + 1)'(PERIOD_CYC))
        else $error("blink counter out of period");
endmodule : blink_gen
`default_nettype wire

// ---- design/fail_pin_ctrl.sv ----
// fail output, alternate pin, interrupt pin and start-up strap logic with wishbone registers
//
// Register access over Wishbone and the register offsets were chosen for this implementation.
`default_nettype none
// Overview of operation
// RULE1 - interrupt pin driven low to flag events
// RULE2 - start-up interrupt pin level picks configuration
// RULE3 - side indicator pin: 1.25 Hz, 50 percent
// RULE4 - pulsed light pin: 100 Hz, 20 percent
// RULE5 - test pin low at power-up: development mode
// RULE6 - fail pins reconfigurable: wake, low, high
// RULE7 - fail function is the reset default
// RULE8 - general-purpose pin never shows fail pattern
// RULE9 - host disables wake on measure-selected pins; the bench masks wake events but leaves the second alternate pin in wake mode
// RULE10 - host disables wake inputs left unused
// RULE11 - blink counters restart cleanly on enable
module fail_pin_ctrl
    import fail_pin_pkg::*;
#(
    parameter int SIDE_PERIOD  = fail_pin_pkg::SIDE_PERIOD_CYC,
    parameter int SIDE_ON      = fail_pin_pkg::SIDE_ON_CYC,
    parameter int LIGHT_PERIOD = fail_pin_pkg::LIGHT_PERIOD_CYC,
    parameter int LIGHT_ON     = fail_pin_pkg::LIGHT_ON_CYC
) (
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    // wishbone slave
    input  wire logic                           cyc_i,
    input  wire logic                           stb_i,
    input  wire logic                           we_i,
    input  wire logic [fail_pin_pkg::ADR_W-1:0] adr_i,
    input  wire logic [3:0]                     sel_i,
    input  wire logic [fail_pin_pkg::DAT_W-1:0] dat_i,
    output logic      [fail_pin_pkg::DAT_W-1:0] dat_o,
    output logic                                ack_o,
    // device events
    input  wire logic                           fail_event_i,
    output logic                                irq_o,
    output logic                                dev_mode_o,
    output logic                                hv_measure_select_o,
    // interrupt pin, active low, sampled as strap at start-up
    input  wire logic                           int_pin_i,
    output logic                                int_pin_out_o,
    output logic                                int_pin_oe_o,
    // side indicator / first alternate pin
    input  wire logic                           side_indicator_in_i,
    output logic                                side_indicator_out_n_o,
    output logic                                side_indicator_oe_o,
    // pulsed light / test strap / second alternate pin
    input  wire logic                           pulsed_light_in_i,
    output logic                                pulsed_light_out_n_o,
    output logic                                pulsed_light_oe_o
);
    import fail_pin_pkg::*;

    localparam int NPIN = 2;

    if (SIDE_ON < 1 || SIDE_ON >= SIDE_PERIOD
        || LIGHT_ON < 1 || LIGHT_ON >= LIGHT_PERIOD) begin : g_chk_blink
        $error("fail_pin_ctrl: blink on time must lie inside its period");
    end
    if (STRAP_WAIT_CYC >= (1 << STRAP_CNT_W)) begin : g_chk_strap
        $error("fail_pin_ctrl: strap wait does not fit its counter");
    end

    typedef enum logic [1:0] {
        ST_WAIT   = 2'h0,
        ST_SAMPLE = 2'h1,
        ST_RUN    = 2'h3
    } phase_t;

    typedef struct packed {
        phase_t                 st;
        logic [STRAP_CNT_W-1:0] wait_cnt;
        logic                   cfg13;
        logic                   dev;
        logic                   ack;
        logic [DAT_W-1:0]       dat;
        logic [CTRL_W-1:0]      ctrl;
        logic [REG_W-1:0]       pin_ctrl;
        logic [EV_W-1:0]        status;
        logic [EV_W-1:0]        mask;
        logic                   irq;
        logic                   int_oe;
        logic [NPIN-1:0]        pin_out;
        logic [NPIN-1:0]        pin_oe;
        logic [NPIN-1:0]        pin_prev;
    } ctrl_state_t;

    ctrl_state_t s_reg;
    ctrl_state_t s_next;

    // pin synchronisers: interrupt pin, side pin, light pin
    logic [2:0] pins_sync;

    pin_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({pulsed_light_in_i, side_indicator_in_i, int_pin_i}),
        .q_o   (pins_sync)
    );

    logic            int_lvl;
    logic [NPIN-1:0] pin_lvl;

    assign int_lvl = pins_sync[0];
    assign pin_lvl = pins_sync[2:1];

    blink_if side_bl ();
    blink_if light_bl ();

    blink_gen #(
        .PERIOD_CYC (SIDE_PERIOD),
        .ON_CYC     (SIDE_ON)
    ) u_side (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .bl    (side_bl)
    );

    blink_gen #(
        .PERIOD_CYC (LIGHT_PERIOD),
        .ON_CYC     (LIGHT_ON)
    ) u_light (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .bl    (light_bl)
    );

    pin_mode_t       mode [NPIN];
    logic [NPIN-1:0] lvl_bit;
    logic [NPIN-1:0] pattern;

    for (genvar i = 0; i < NPIN; i++) begin : g_pin_field
        assign mode[i]    = pin_mode_t'(s_reg.pin_ctrl[i*PIN_FIELD_W +: 2]);
        assign lvl_bit[i] = s_reg.pin_ctrl[i*PIN_FIELD_W + PIN_LVL_OFS];
    end

    // pattern generators run only while the pin keeps its fail function
    assign side_bl.en  = (s_reg.st == ST_RUN) && s_reg.ctrl[CTRL_SIDE_BIT]
                         && (mode[0] == MODE_FAIL); // RULE8
    assign light_bl.en = (s_reg.st == ST_RUN) && s_reg.ctrl[CTRL_LIGHT_BIT]
                         && (mode[1] == MODE_FAIL); // RULE8
    assign pattern     = {light_bl.active, side_bl.active};

    logic             req;
    logic             wr;
    logic [EV_W-1:0]  ev;
    logic [DAT_W-1:0] rd;

    assign req = cyc_i && stb_i && !s_reg.ack;
    assign wr  = req && we_i && sel_i[0];

    always_comb begin
        rd = '0;
        case (adr_i)
            OFS_CTRL:     rd[CTRL_W-1:0] = s_reg.ctrl;
            OFS_PIN_CTRL: rd[REG_W-1:0]  = s_reg.pin_ctrl;
            OFS_STATUS:   rd[EV_W-1:0]   = s_reg.status;
            OFS_MASK:     rd[EV_W-1:0]   = s_reg.mask;
            OFS_INFO: begin
                rd[INFO_CFG13_BIT] = s_reg.cfg13;
                rd[INFO_DEV_BIT]   = s_reg.dev;
                rd[INFO_RUN_BIT]   = (s_reg.st == ST_RUN);
            end
            default:      rd = '0;
        endcase
    end

    always_comb begin
        s_next = s_reg;
        ev     = '0;
        // start-up: pins released, then the straps are read once
        case (s_reg.st)
            ST_WAIT: begin
                s_next.wait_cnt = s_reg.wait_cnt + STRAP_CNT_W'(1);
                if (s_reg.wait_cnt == STRAP_CNT_W'(STRAP_WAIT_CYC - 1)) begin
                    s_next.st = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                s_next.cfg13 = int_lvl; // RULE2
                s_next.dev   = !pin_lvl[1]; // RULE5
                s_next.st    = ST_RUN;
            end
            ST_RUN: begin
                s_next.st = ST_RUN;
            end
            default: begin
                s_next.st = ST_WAIT;
            end
        endcase

        // wake events from pins set to wake input
        s_next.pin_prev = pin_lvl;
        for (int i = 0; i < NPIN; i++) begin
            if (s_reg.st == ST_RUN && mode[i] == MODE_WAKE
                && pin_lvl[i] != s_reg.pin_prev[i]) begin
                ev[EV_WAKE1_BIT + i] = 1'b1; // RULE6
            end
        end
        ev[EV_FAIL_BIT] = fail_event_i;

        // bus access, one wait state
        s_next.ack = req;
        s_next.dat = req && !we_i ? rd : '0;
        if (wr && adr_i == OFS_CTRL) begin
            s_next.ctrl = dat_i[CTRL_W-1:0];
        end
        if (wr && adr_i == OFS_PIN_CTRL) begin
            s_next.pin_ctrl = dat_i[REG_W-1:0]; // RULE7
        end
        if (wr && adr_i == OFS_MASK) begin
            s_next.mask = dat_i[EV_W-1:0];
        end
        // write one to clear; a new event in the same cycle wins
        if (wr && adr_i == OFS_STATUS) begin
            s_next.status = s_reg.status & ~dat_i[EV_W-1:0];
        end
        s_next.status = s_next.status | ev;
        s_next.irq    = |(s_next.status & s_next.mask);
        s_next.int_oe = s_next.irq && (s_reg.st == ST_RUN); // RULE1

        // pin drivers per function
        for (int i = 0; i < NPIN; i++) begin
            case (mode[i])
                MODE_FAIL: begin
                    s_next.pin_out[i] = 1'b0;
                    s_next.pin_oe[i]  = pattern[i]; // RULE3 RULE4
                end
                MODE_WAKE: begin
                    s_next.pin_out[i] = 1'b0;
                    s_next.pin_oe[i]  = 1'b0; // RULE8
                end
                MODE_LOW: begin
                    s_next.pin_out[i] = 1'b0;
                    s_next.pin_oe[i]  = lvl_bit[i]; // RULE6
                end
                MODE_HIGH: begin
                    s_next.pin_out[i] = 1'b1;
                    s_next.pin_oe[i]  = lvl_bit[i]; // RULE6
                end
                default: begin
                    s_next.pin_out[i] = 1'b0;
                    s_next.pin_oe[i]  = 1'b0;
                end
            endcase
            if (s_reg.st != ST_RUN) begin
                s_next.pin_oe[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg          <= '0;
            s_reg.st       <= ST_WAIT;
            s_reg.ctrl     <= CTRL_RST;
            s_reg.pin_ctrl <= PIN_CTRL_RST; // RULE7
            s_reg.status   <= EV_RST;
            s_reg.mask     <= EV_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign dat_o                  = s_reg.dat;
    assign ack_o                  = s_reg.ack;
    assign irq_o                  = s_reg.irq;
    assign dev_mode_o             = s_reg.dev;
    assign hv_measure_select_o    = s_reg.ctrl[CTRL_MEAS_BIT];
    assign int_pin_out_o          = 1'b0;
    assign int_pin_oe_o           = s_reg.int_oe;
    assign side_indicator_out_n_o = s_reg.pin_out[0];
    assign side_indicator_oe_o    = s_reg.pin_oe[0];
    assign pulsed_light_out_n_o   = s_reg.pin_out[1];
    assign pulsed_light_oe_o      = s_reg.pin_oe[1];

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_bus_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_bus_ack_after: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered in one cycle");
    a_int_pin_level: assert property (int_pin_oe_o |-> irq_o && !int_pin_out_o) // RULE1
        else $error("interrupt pin low without pending interrupt");
    a_int_quiet_startup: assert property (s_reg.st != ST_RUN |=> !int_pin_oe_o) // RULE2
        else $error("interrupt pin driven during strap phase");
    a_strap_cfg_taken: assert property (s_reg.st == ST_SAMPLE // RULE2
        |=> s_reg.cfg13 == $past(int_lvl))
        else $error("configuration strap not captured");
    a_strap_dev_taken: assert property (s_reg.st == ST_SAMPLE // RULE5
        |=> s_reg.dev == !$past(pin_lvl[1]))
        else $error("development strap not captured");
    a_fail_irq_set: assert property (fail_event_i // RULE1
        |=> s_reg.status[EV_FAIL_BIT] && (irq_o || !s_reg.mask[EV_FAIL_BIT]))
        else $error("failure event lost");
    a_side_follow: assert property (mode[0] == MODE_FAIL && s_reg.st == ST_RUN // RULE3
        |=> side_indicator_oe_o == $past(side_bl.active) && !side_indicator_out_n_o)
        else $error("side pin not following its pattern");
    a_light_follow: assert property (mode[1] == MODE_FAIL && s_reg.st == ST_RUN // RULE4
        |=> pulsed_light_oe_o == $past(light_bl.active) && !pulsed_light_out_n_o)
        else $error("light pin not following its pattern");
    a_gpio_no_fail: assert property (mode[0] == MODE_WAKE ##1 mode[0] == MODE_WAKE // RULE8
        |-> !side_indicator_oe_o)
        else $error("fail pattern on general-purpose pin");
    a_por_fail_mode: assert property ($past(rst_i) |-> s_reg.pin_ctrl == PIN_CTRL_RST) // RULE7
        else $error("pins not in fail function after reset");
    a_high_side_drive: assert property (mode[1] == MODE_HIGH && lvl_bit[1] // RULE6
        && s_reg.st == ST_RUN |=> pulsed_light_oe_o && pulsed_light_out_n_o)
        else $error("high-side switch not driven");
    a_low_side_drive: assert property (mode[0] == MODE_LOW && lvl_bit[0] // RULE6
        && s_reg.st == ST_RUN |=> side_indicator_oe_o && !side_indicator_out_n_o)
        else $error("low-side switch not driven");
    a_light_no_fail: assert property (mode[1] == MODE_WAKE ##1 mode[1] == MODE_WAKE // RULE8
        |-> !pulsed_light_oe_o)
        else $error("fail pattern on second alternate pin");
    a_status_set_wins: assert property (ev != '0 // RULE1
        |=> (s_reg.status & $past(ev)) == $past(ev))
        else $error("event lost against a status clear");
    // a disabled pattern releases its fail pin two cycles later
    a_side_idle: assert property (!side_bl.en ##1 !side_bl.en && mode[0] == MODE_FAIL // RULE3
        |=> !side_indicator_oe_o)
        else $error("side pin driven with pattern off");
    a_light_idle: assert property (!light_bl.en ##1 !light_bl.en && mode[1] == MODE_FAIL // RULE4
        |=> !pulsed_light_oe_o)
        else $error("light pin driven with pattern off");
    a_pins_quiet_startup: assert property (s_reg.st != ST_RUN // RULE5
        |=> !side_indicator_oe_o && !pulsed_light_oe_o)
        else $error("fail pin driven during strap phase");

    c_bus_read: cover property (cyc_i && stb_i && !we_i ##1 ack_o);
    c_irq_rise: cover property ($rose(irq_o));
    c_side_blink: cover property ($rose(side_indicator_oe_o));
    c_light_blink: cover property ($fell(pulsed_light_oe_o));
    c_wake_event: cover property ($rose(s_reg.status[EV_WAKE1_BIT]));
endmodule : fail_pin_ctrl
`default_nettype wire

// ---- design/pin_sync.sv ----
// two flip-flop synchroniser for asynchronous pin levels
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    if (WIDTH < 1) begin : g_chk
        $error("pin_sync: width must be at least one");
    end

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t s_reg;
    sync_state_t s_next;

    always_comb begin
        s_next.meta   = d_i;
        s_next.stable = s_reg.meta;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign q_o = s_reg.stable;
endmodule : pin_sync
`default_nettype wire

// ---- dv/pin_board.sv ----
// board model: pull-ups, straps and outside levels on the device pins
`default_nettype none
module pin_board (
    input  wire logic int_oe_i,
    input  wire logic int_out_i,
    input  wire logic side_oe_i,
    input  wire logic side_out_i,
    input  wire logic light_oe_i,
    input  wire logic light_out_i,
    input  wire logic int_pullup_i,
    input  wire logic test_gnd_i,
    input  wire logic [1:0] ext_low_i,
    output logic      int_pin_o,
    output logic      side_pin_o,
    output logic      light_pin_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // without the outside pull-up the device's own pull-down decides
    assign int_pin_o   = int_oe_i ? int_out_i : int_pullup_i;
    // open drain with a board pull-up, pulled low by an outside switch
    assign side_pin_o  = side_oe_i ? side_out_i : ~ext_low_i[0];
    // grounding the test pin overrides the integrated pull-up
    assign light_pin_o = light_oe_i ? light_out_i : ~(test_gnd_i | ext_low_i[1]);
endmodule : pin_board
`default_nettype wire

// ---- dv/test_fail_pin_ctrl.sv ----
// self-checking bench for the fail and alternate pin block
`default_nettype none
module test_fail_pin_ctrl import fail_pin_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SP = 20;
    localparam int SO = 10;
    localparam int LP = 10;
    localparam int LO = 2;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, fail_event_i, int_pullup, test_gnd;
    logic [7:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o;
    logic [1:0]  ext_low;
    logic        ack_o, irq_o, dev_mode_o, hv_measure_select_o, int_pin_out_o, int_pin_oe_o;
    logic        side_indicator_out_n_o, side_indicator_oe_o;
    logic        pulsed_light_out_n_o, pulsed_light_oe_o;
    wire logic   int_pin_i, side_indicator_in_i, pulsed_light_in_i;
    logic [31:0] exp_q [$];
    logic [7:0]  modes [5] = '{8'h01, 8'h05, 8'h06, 8'h07, 8'h03};
    int          n_errors = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          seed = 15121;
    logic [31:0] v;

    fail_pin_ctrl #(.SIDE_PERIOD(SP), .SIDE_ON(SO), .LIGHT_PERIOD(LP), .LIGHT_ON(LO)) i_dut (
        .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .fail_event_i, .irq_o, .dev_mode_o, .hv_measure_select_o,
        .int_pin_i, .int_pin_out_o, .int_pin_oe_o,
        .side_indicator_in_i, .side_indicator_out_n_o, .side_indicator_oe_o,
        .pulsed_light_in_i, .pulsed_light_out_n_o, .pulsed_light_oe_o
    );

    pin_board i_board (
        .int_oe_i(int_pin_oe_o), .int_out_i(int_pin_out_o),
        .side_oe_i(side_indicator_oe_o), .side_out_i(side_indicator_out_n_o),
        .light_oe_i(pulsed_light_oe_o), .light_out_i(pulsed_light_out_n_o),
        .int_pullup_i(int_pullup), .test_gnd_i(test_gnd), .ext_low_i(ext_low),
        .int_pin_o(int_pin_i), .side_pin_o(side_indicator_in_i),
        .light_pin_o(pulsed_light_in_i)
    );

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic print_verdict();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= s;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hF);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0, 4'hF);
    endtask : rd

    task automatic rst_seq(input logic pu, input logic tg);
        @(posedge clk_i);
        rst_i      <= 1'b1;
        int_pullup <= pu;
        test_gnd   <= tg;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (210) @(posedge clk_i);
        test_gnd <= 1'b0;
    endtask : rst_seq

    function automatic logic oe_of(input int l);
        return l ? pulsed_light_oe_o : side_indicator_oe_o;
    endfunction : oe_of

    function automatic logic out_of(input int l);
        return l ? pulsed_light_out_n_o : side_indicator_out_n_o;
    endfunction : out_of

    // measures the first low-driven span and the following released span
    task automatic pat(input int l, input int on, input int per);
        int n;
        while (oe_of(l) !== 1'b1) @(posedge clk_i);
        for (int h = 0; h < 2; h++) begin
            n = 0;
            while (oe_of(l) === (h == 0)) begin
                if (h == 0) check("pattern level", out_of(l), 0);
                n++;
                @(posedge clk_i);
            end
            check("pattern span", n, h ? per - on : on);
        end
    endtask : pat

    // read data compared against the oldest note at every read acknowledge
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0) check("read data", dat_o, exp_q.pop_front());
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            print_verdict();
        end
    end

    initial begin
        {rst_i, cyc_i, stb_i, we_i, fail_event_i, int_pullup, test_gnd} = 7'h40;
        {adr_i, sel_i, dat_i, ext_low} = '0;
        rst_seq(1'b1, 1'b1);
        rd(OFS_INFO, 32'h7);
        check("dev mode", dev_mode_o, 1);
        rst_seq(1'b0, 1'b0);
        rd(OFS_INFO, 32'h4);
        check("dev mode", dev_mode_o, 0);
        rd(OFS_CTRL, 32'h0);
        rd(OFS_PIN_CTRL, 32'h0);
        rd(OFS_STATUS, 32'h0);
        rd(OFS_MASK, 32'h0);
        check("side drive", side_indicator_oe_o, 0);
        check("light drive", pulsed_light_oe_o, 0);
        wr(8'h14, 32'hFF);
        rd(8'h14, 32'h0);
        wb(1'b1, OFS_MASK, 32'hFF, 4'h0);
        rd(OFS_MASK, 32'h0);
        repeat (4) begin
            v = $random(seed);
            wr(OFS_MASK, v);
            rd(OFS_MASK, v & 32'h7);
        end
        wr(OFS_MASK, 32'h0);
        wr(OFS_CTRL, 32'h1);
        pat(0, SO, SP);
        wr(OFS_CTRL, 32'h2);
        pat(1, LO, LP);
        wr(OFS_CTRL, 32'h3);
        for (int p = 0; p < 2; p++) begin
            foreach (modes[i]) begin
                wr(OFS_PIN_CTRL, 32'(modes[i]) << (4 * p));
                repeat (3) @(posedge clk_i);
                repeat (SP) begin
                    check("pin drive", oe_of(p), modes[i][1] & modes[i][2]);
                    if (modes[i][1] & modes[i][2]) begin
                        check("pin level", out_of(p), modes[i][0]);
                    end
                    @(posedge clk_i);
                end
            end
        end
        wr(OFS_PIN_CTRL, 32'h0);
        wr(OFS_CTRL, 32'h0);
        wr(OFS_STATUS, 32'h7);
        for (int p = 0; p < 2; p++) begin
            wr(OFS_PIN_CTRL, 32'h1 << (4 * p));
            wr(OFS_MASK, 32'h2 << p);
            ext_low[p] <= 1'b1;
            repeat (6) @(posedge clk_i);
            check("irq", irq_o, 1);
            check("int pin drive", int_pin_oe_o, 1);
            check("int pin level", int_pin_out_o, 0);
            rd(OFS_STATUS, 32'h2 << p);
            ext_low[p] <= 1'b0;
            repeat (6) @(posedge clk_i);
            wr(OFS_STATUS, 32'h7);
            rd(OFS_STATUS, 32'h0);
            check("irq", irq_o, 0);
        end
        wr(OFS_MASK, 32'h0);
        fail_event_i <= 1'b1;
        @(posedge clk_i);
        fail_event_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        check("irq", irq_o, 0);
        rd(OFS_STATUS, 32'h1);
        wr(OFS_MASK, 32'h1);
        repeat (2) @(posedge clk_i);
        check("int pin drive", int_pin_oe_o, 1);
        wr(OFS_STATUS, 32'h1);
        repeat (2) @(posedge clk_i);
        check("int pin drive", int_pin_oe_o, 0);
        // wake sources stay masked while measuring; the second alternate pin is left in wake mode
        wr(OFS_MASK, 32'h0);
        wr(OFS_CTRL, 32'h4);
        repeat (2) @(posedge clk_i);
        check("measure select", hv_measure_select_o, 1);
        rd(OFS_CTRL, 32'h4);
        print_verdict();
    end
endmodule : test_fail_pin_ctrl
`default_nettype wire
